// *** rtl/txl_pkg.sv ***
// Purpose: Shared constants and carriers for the transmit buffer command loader.
// Assumes: APB slave on pclk at 40 MHz, 32-bit data, one word per register.
// Notes:   Command and status field positions are collected here.
package txl_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_DATA     = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_SPACE    = 8'h08;
  localparam logic [7:0] ADDR_INT_STS  = 8'h0c;
  localparam logic [7:0] ADDR_INT_MASK = 8'h10;
  localparam logic [7:0] ADDR_CONFIG   = 8'h14;
  localparam logic [7:0] ADDR_CTRL     = 8'h18;

  // Command A fields
  localparam int A_IOC     = 31;
  localparam int A_ALN_HI  = 25;
  localparam int A_ALN_LO  = 24;
  localparam int A_OFF_HI  = 20;
  localparam int A_OFF_LO  = 16;
  localparam int A_FIRST   = 13;
  localparam int A_LAST    = 12;
  localparam int A_SIZE_HI = 10;

  // Command B fields
  localparam int B_TAG_HI  = 31;
  localparam int B_TAG_LO  = 16;
  localparam int B_LEN_HI  = 10;

  // End alignment codes
  localparam logic [1:0] ALIGN_4    = 2'h0;
  localparam logic [1:0] ALIGN_16   = 2'h1;
  localparam logic [1:0] ALIGN_32   = 2'h2;
  localparam logic [1:0] ALIGN_RSVD = 2'h3;

  // Interrupt status bits
  localparam int INT_ERR    = 0;
  localparam int INT_LOADED = 1;
  localparam int INT_LEVEL  = 2;
  localparam int INT_W      = 3;

  // Status word fields
  localparam int ST_TAG_LO   = 16;
  localparam int ST_ERR_SUM  = 15;
  localparam int ST_LOAD_ERR = 1;
  localparam int ST_MAC_FAIL = 0;

  // Values after reset and default sizes
  localparam logic [7:0]       THR_RST      = 8'h00;
  localparam logic [INT_W-1:0] MASK_RST     = 3'h0;
  localparam int               DATA_DEPTH   = 16;
  localparam int               STATUS_DEPTH = 16;

  typedef enum logic [1:0] {
    LD_CMD_A = 2'b00,
    LD_CMD_B = 2'b01,
    LD_DATA  = 2'b10,
    LD_FIN   = 2'b11
  } load_state_e;

  // One data FIFO entry as seen by the MAC
  typedef struct packed {
    logic [31:0] data;
    logic [3:0]  be;
    logic        last;
    logic [15:0] tag;
    logic        err;
  } tx_word_s;

endpackage

// *** rtl/status_fifo.sv ***
// Purpose: Transmit status FIFO holding one word per finished packet.
// Assumes: DEPTH is a power of two; push is ignored while full.
// Notes:   Head word is visible on dout without a pop.
`timescale 1ns/1ps
module status_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = txl_pkg::STATUS_DEPTH
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       ce,
  input  wire logic                       push,
  input  wire logic [W-1:0]               din,
  input  wire logic                       pop,
  output logic      [W-1:0]               dout,
  output logic      [$clog2(DEPTH+1)-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [CW-1:0]           cnt;
  } state_s;

  state_s st_ff;
  state_s nxt_st;
  logic   do_push;
  logic   do_pop;

  // Pointer and count update
  always_comb begin
    nxt_st  = st_ff;
    do_push = push && (st_ff.cnt != CW'(DEPTH));
    do_pop  = pop && (st_ff.cnt != '0);
    if (do_push) begin
      nxt_st.mem[st_ff.wp] = din;
      nxt_st.wp            = st_ff.wp + 1'b1;
    end
    if (do_pop) begin
      nxt_st.rp = st_ff.rp + 1'b1;
    end
    nxt_st.cnt = st_ff.cnt + CW'(do_push) - CW'(do_pop);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign dout  = st_ff.mem[st_ff.rp];
  assign count = st_ff.cnt;
endmodule // status_fifo

// *** rtl/tx_buffer_command_loader.sv ***
// Purpose: Loads command-prefixed transmit buffers into the data FIFO for the MAC.
// Assumes: APB master on pclk; MAC logic on pclk; DATA_DEPTH is a power of two.
// Notes:   A zero-enable trailer entry with last set closes each packet, unless the data FIFO is full at the end.
`timescale 1ns/1ps
module tx_buffer_command_loader #(
  parameter int DATA_DEPTH   = txl_pkg::DATA_DEPTH,
  parameter int STATUS_DEPTH = txl_pkg::STATUS_DEPTH
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   tx_valid,
  output txl_pkg::tx_word_s      tx_word,
  input  wire logic              tx_ready,
  input  wire logic              tx_done,
  input  wire logic              tx_fail,
  output logic                   irq,
  output logic                   transmit_error_flag,
  output logic                   buffer_loaded_flag
);
  localparam int AW  = $clog2(DATA_DEPTH);
  localparam int CW  = $clog2(DATA_DEPTH+1);
  localparam int SCW = $clog2(STATUS_DEPTH+1);

  typedef struct packed {
    txl_pkg::load_state_e                      ld;
    logic [31:0]                               cmd_a;
    logic [31:0]                               cmd_b;
    logic [31:0]                               first_b;
    logic                                      in_pkt;
    logic [11:0]                               pkt_bytes;
    logic                                      pkt_err;
    logic [9:0]                                wcnt;
    logic [9:0]                                tot;
    logic [11:0]                               endb;
    logic [4:0]                                off;
    logic [DATA_DEPTH-1:0][$bits(txl_pkg::tx_word_s)-1:0] mem;
    logic [AW-1:0]                             wp;
    logic [AW-1:0]                             rp;
    logic [CW-1:0]                             cnt;
    logic                                      out_valid;
    txl_pkg::tx_word_s                         out_word;
    logic [15:0]                               fly_tag;
    logic                                      fly_err;
    logic                                      err_flag;
    logic [txl_pkg::INT_W-1:0]                 int_sts;
    logic [txl_pkg::INT_W-1:0]                 int_mask;
    logic [7:0]                                thr;
    logic                                      irq;
    logic                                      pready;
    logic                                      pslverr;
    logic [31:0]                               prdata;
    logic                                      st_taken;
  } state_s;

  state_s            st_ff;
  state_s            nxt_st;
  logic              access;
  logic              wr_data;
  logic              st_push;
  logic [31:0]       st_din;
  logic              st_pop;
  logic [31:0]       st_dout;
  logic [SCW-1:0]    st_cnt;
  logic              err_evt;
  logic              load_evt;
  logic              push;
  txl_pkg::tx_word_s push_word;
  logic              pop;
  logic [3:0]        be;
  logic [11:0]       words;
  logic [9:0]        am;
  logic              len_bad;
  logic [31:0]       clr;

  // Known register offsets
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == txl_pkg::ADDR_DATA)     || (a == txl_pkg::ADDR_STATUS)  ||
              (a == txl_pkg::ADDR_SPACE)    || (a == txl_pkg::ADDR_INT_STS) ||
              (a == txl_pkg::ADDR_INT_MASK) || (a == txl_pkg::ADDR_CONFIG)  ||
              (a == txl_pkg::ADDR_CTRL);
  endfunction

  // Byte lanes of a buffer word that lie between start offset and end
  function automatic logic [3:0] be_of(input logic [9:0]  w,
                                       input logic [4:0]  o,
                                       input logic [11:0] e);
    logic [11:0] pos;
    pos = '0;
    for (int i = 0; i < 4; i++) begin
      pos     = {w, 2'b00} + 12'(i);
      be_of[i] = (pos >= {7'h00, o}) && (pos < e);
    end
  endfunction

  // Number of kept bytes in a word
  function automatic logic [11:0] bytes_of(input logic [3:0] b);
    bytes_of = 12'(b[0]) + 12'(b[1]) + 12'(b[2]) + 12'(b[3]);
  endfunction

  status_fifo #(
    .W     (32),
    .DEPTH (STATUS_DEPTH)
  ) u_status (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .push    (st_push),
    .din     (st_din),
    .pop     (st_pop),
    .dout    (st_dout),
    .count   (st_cnt)
  );

  // Bus, loader, FIFO and interrupt next state
  always_comb begin
    nxt_st    = st_ff;
    access    = psel && penable && st_ff.pready;
    wr_data   = access && pwrite && (paddr == txl_pkg::ADDR_DATA);
    err_evt   = 1'b0;
    load_evt  = 1'b0;
    push      = 1'b0;
    push_word = '0;
    pop       = 1'b0;
    be        = '0;
    words     = '0;
    am        = '0;
    len_bad   = 1'b0;
    clr       = '0;

    // Zero-wait APB: pready and answer registered in the setup cycle
    nxt_st.pready  = psel && !penable;
    nxt_st.pslverr = psel && !penable && !addr_ok(paddr);
    nxt_st.prdata  = '0;
    // Pop only a status word that was really returned in this transfer
    nxt_st.st_taken = psel && !penable && !pwrite && (paddr == txl_pkg::ADDR_STATUS) &&
                      (st_cnt != '0);
    if (psel && !penable && !pwrite) begin
      case (paddr)
        txl_pkg::ADDR_STATUS:   nxt_st.prdata = (st_cnt != '0) ? st_dout : 32'h0;
        txl_pkg::ADDR_SPACE:    nxt_st.prdata = {8'h00, 8'(st_cnt),
                                  16'((DATA_DEPTH - int'(st_ff.cnt)) * 4)};
        txl_pkg::ADDR_INT_STS:  nxt_st.prdata = 32'(st_ff.int_sts);
        txl_pkg::ADDR_INT_MASK: nxt_st.prdata = 32'(st_ff.int_mask);
        txl_pkg::ADDR_CONFIG:   nxt_st.prdata = {24'h0, st_ff.thr};
        txl_pkg::ADDR_CTRL:     nxt_st.prdata = {31'h0, st_ff.err_flag};
        default:                nxt_st.prdata = '0;
      endcase
    end

    // Command and payload loader
    case (st_ff.ld)
      txl_pkg::LD_CMD_A: begin
        if (wr_data) begin
          nxt_st.cmd_a = pwdata;
          nxt_st.ld    = txl_pkg::LD_CMD_B;
          if (pwdata[txl_pkg::A_ALN_HI:txl_pkg::A_ALN_LO] == txl_pkg::ALIGN_RSVD) begin
            err_evt = 1'b1;
          end
        end
      end
      txl_pkg::LD_CMD_B: begin
        if (wr_data) begin
          nxt_st.cmd_b = pwdata;
          if (st_ff.cmd_a[txl_pkg::A_FIRST]) begin
            nxt_st.in_pkt    = 1'b1;
            nxt_st.first_b   = pwdata;
            nxt_st.pkt_bytes = '0;
            nxt_st.pkt_err   = (st_ff.cmd_a[txl_pkg::A_ALN_HI:txl_pkg::A_ALN_LO] ==
                                txl_pkg::ALIGN_RSVD);
          end else if (!st_ff.in_pkt || (pwdata != st_ff.first_b)) begin
            err_evt = 1'b1;
          end
          // Each buffer has its own start offset and end
          nxt_st.off  = st_ff.cmd_a[txl_pkg::A_OFF_HI:txl_pkg::A_OFF_LO];
          nxt_st.endb = 12'(st_ff.cmd_a[txl_pkg::A_OFF_HI:txl_pkg::A_OFF_LO]) +
                        12'(st_ff.cmd_a[txl_pkg::A_SIZE_HI:0]);
          words = (nxt_st.endb + 12'h003) >> 2;
          case (st_ff.cmd_a[txl_pkg::A_ALN_HI:txl_pkg::A_ALN_LO])
            txl_pkg::ALIGN_16: am = 10'h003;
            txl_pkg::ALIGN_32: am = 10'h007;
            default:           am = 10'h000;
          endcase
          nxt_st.tot  = (10'(words) + am) & ~am;
          nxt_st.wcnt = '0;
          nxt_st.ld   = (nxt_st.tot == '0) ? txl_pkg::LD_FIN : txl_pkg::LD_DATA;
        end
      end
      txl_pkg::LD_DATA: begin
        if (wr_data) begin
          be = be_of(st_ff.wcnt, st_ff.off, st_ff.endb);
          if (be != '0) begin
            if (st_ff.cnt == CW'(DATA_DEPTH)) begin
              err_evt = 1'b1;
            end else begin
              push           = 1'b1;
              push_word.data = pwdata;
              push_word.be   = be;
              push_word.tag  = st_ff.cmd_b[txl_pkg::B_TAG_HI:txl_pkg::B_TAG_LO];
            end
            nxt_st.pkt_bytes = st_ff.pkt_bytes + bytes_of(be);
          end
          nxt_st.wcnt = st_ff.wcnt + 10'h001;
          if (nxt_st.wcnt == st_ff.tot) begin
            nxt_st.ld = txl_pkg::LD_FIN;
          end
        end
      end
      txl_pkg::LD_FIN: begin
        load_evt  = st_ff.cmd_a[txl_pkg::A_IOC];
        nxt_st.ld = txl_pkg::LD_CMD_A;
        if (st_ff.cmd_a[txl_pkg::A_LAST]) begin
          len_bad = st_ff.pkt_bytes != {1'b0, st_ff.first_b[txl_pkg::B_LEN_HI:0]};
          err_evt = len_bad;
          nxt_st.in_pkt = 1'b0;
          if (st_ff.cnt == CW'(DATA_DEPTH)) begin
            err_evt = 1'b1;
          end else begin
            push           = 1'b1;
            push_word.last = 1'b1;
            push_word.tag  = st_ff.first_b[txl_pkg::B_TAG_HI:txl_pkg::B_TAG_LO];
            push_word.err  = st_ff.pkt_err || len_bad;
          end
        end
      end
      default: nxt_st.ld = txl_pkg::LD_CMD_A;
    endcase
    if (err_evt && st_ff.in_pkt) begin
      nxt_st.pkt_err = 1'b1;
    end

    // Output stage toward the MAC refills from the FIFO head
    if ((!st_ff.out_valid || tx_ready) && (st_ff.cnt != '0)) begin
      pop              = 1'b1;
      nxt_st.out_word  = st_ff.mem[st_ff.rp];
      nxt_st.out_valid = 1'b1;
      nxt_st.rp        = st_ff.rp + 1'b1;
    end else if (tx_ready) begin
      nxt_st.out_valid = 1'b0;
    end
    if (push) begin
      nxt_st.mem[st_ff.wp] = push_word;
      nxt_st.wp            = st_ff.wp + 1'b1;
    end
    nxt_st.cnt = st_ff.cnt + CW'(push) - CW'(pop);

    // Packet handed to the MAC; its tag waits for the done pulse
    if (st_ff.out_valid && tx_ready && st_ff.out_word.last) begin
      nxt_st.fly_tag = st_ff.out_word.tag;
      nxt_st.fly_err = st_ff.out_word.err;
    end

    // Register writes
    if (access && pwrite) begin
      case (paddr)
        txl_pkg::ADDR_INT_MASK: nxt_st.int_mask = pwdata[txl_pkg::INT_W-1:0];
        txl_pkg::ADDR_CONFIG:   nxt_st.thr      = pwdata[7:0];
        default:                nxt_st.thr      = nxt_st.thr;
      endcase
    end
    if (access && pwrite && (paddr == txl_pkg::ADDR_CTRL) && pwdata[0]) begin
      clr[0] = 1'b1;
    end
    nxt_st.err_flag = (st_ff.err_flag && !clr[0]) || err_evt;

    // Sticky interrupt bits; read clears what was returned, a new event wins
    if (access && !pwrite && (paddr == txl_pkg::ADDR_INT_STS)) begin
      clr[31:1] = {28'h0, st_ff.prdata[txl_pkg::INT_W-1:0]};
    end
    nxt_st.int_sts = st_ff.int_sts & ~clr[txl_pkg::INT_W:1];
    nxt_st.int_sts[txl_pkg::INT_ERR]    = nxt_st.int_sts[txl_pkg::INT_ERR] || err_evt;
    nxt_st.int_sts[txl_pkg::INT_LOADED] = nxt_st.int_sts[txl_pkg::INT_LOADED] || load_evt;
    nxt_st.int_sts[txl_pkg::INT_LEVEL]  = nxt_st.int_sts[txl_pkg::INT_LEVEL] ||
      ((st_ff.thr != '0) && (32'(st_cnt) >= 32'(st_ff.thr)));
    nxt_st.irq = |(nxt_st.int_sts & nxt_st.int_mask);
  end

  // Status word per transmission and pop on status port read
  always_comb begin
    st_push = tx_done;
    st_din  = '0;
    st_din[31:txl_pkg::ST_TAG_LO]   = st_ff.fly_tag;
    st_din[txl_pkg::ST_ERR_SUM]     = tx_fail || st_ff.fly_err;
    st_din[txl_pkg::ST_LOAD_ERR]    = st_ff.fly_err;
    st_din[txl_pkg::ST_MAC_FAIL]    = tx_fail;
    st_pop  = access && !pwrite && (paddr == txl_pkg::ADDR_STATUS) && st_ff.st_taken;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff          <= '0;
      st_ff.thr      <= txl_pkg::THR_RST;
      st_ff.int_mask <= txl_pkg::MASK_RST;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  assign prdata              = st_ff.prdata;
  assign pready              = st_ff.pready;
  assign pslverr             = st_ff.pslverr;
  assign tx_valid            = st_ff.out_valid;
  assign tx_word             = st_ff.out_word;
  assign irq                 = st_ff.irq;
  assign transmit_error_flag = st_ff.err_flag;
  assign buffer_loaded_flag  = st_ff.int_sts[txl_pkg::INT_LOADED];
endmodule // tx_buffer_command_loader

// *** verif/tx_loader_assertions.sv ***
// Purpose: Port-level checks of the loader's APB and MAC sides.
// Assumes: One pclk domain, presetn active low.
// Notes:   Bound to every loader instance.
`timescale 1ns/1ps
module loader_checker #(
  parameter int DATA_DEPTH   = 16,
  parameter int STATUS_DEPTH = 16
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              ce,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              tx_valid,
  input wire txl_pkg::tx_word_s tx_word,
  input wire logic              tx_ready,
  input wire logic              transmit_error_flag
);
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bus phases
  sequence s_setup;
    ce && psel && !penable;
  endsequence
  sequence s_rd(logic [7:0] a);
    psel && penable && pready && !pwrite && paddr == a;
  endsequence
  sequence s_clr;
    psel && penable && pready && pwrite && paddr == txl_pkg::ADDR_CTRL && pwdata[0];
  endsequence
  a_setup_answer: assert property (s_setup |=> pready)
    else $error("no answer after setup");
  a_answer_single: assert property (ce && pready |=> !pready)
    else $error("answer held too long");
  a_unmapped_err: assert property (s_setup |=> pslverr == ($past(paddr) > 8'h18
    || ($past(paddr) & 8'h03) != 8'h00)) else $error("error response wrong");
  a_space_bound: assert property (s_rd(txl_pkg::ADDR_SPACE) |->
    prdata[15:0] <= 16'(DATA_DEPTH * 4) && prdata[1:0] == 2'h0) else $error("space wrong");
  a_err_sticky: assert property ($fell(transmit_error_flag) |->
    $past(psel && penable && pready && pwrite && paddr == txl_pkg::ADDR_CTRL && pwdata[0]))
    else $error("error flag dropped alone");
  a_err_clear: assert property (ce ##0 s_clr |=> !transmit_error_flag)
    else $error("error flag not cleared");
  a_ctrl_mirror: assert property (s_rd(txl_pkg::ADDR_CTRL) |->
    prdata[0] == $past(transmit_error_flag)) else $error("error bit read wrong");
  a_valid_hold: assert property (ce && tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_word)) else $error("entry changed before taken");
  a_trailer_empty: assert property (tx_valid && tx_word.last |-> tx_word.be == 4'h0)
    else $error("trailer carries bytes");
  a_kept_only: assert property (tx_valid && !tx_word.last |-> tx_word.be != 4'h0)
    else $error("empty word stored");
endmodule // loader_checker
bind tx_buffer_command_loader loader_checker #(
  .DATA_DEPTH(DATA_DEPTH), .STATUS_DEPTH(STATUS_DEPTH)) u_chk (.pclk(pclk),
  .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_valid(tx_valid), .tx_word(tx_word), .tx_ready(tx_ready),
  .transmit_error_flag(transmit_error_flag));

// *** verif/mac_model.sv ***
// Purpose: Behavioural MAC taking loader entries and ending packets.
// Assumes: One packet in flight; stall and fail come from the bench.
// Notes:   Kept bytes are queued in got for the bench to compare.
`timescale 1ns/1ps
module mac_model (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              tx_valid,
  input  wire txl_pkg::tx_word_s tx_word,
  output logic                   tx_ready,
  output logic                   tx_done,
  output logic                   tx_fail,
  input  wire logic              stall,
  input  wire logic              fail
);
  logic [7:0] got[$];
  int         seed = 28;
  int         dly  = -1;
  // Random back-pressure; no new entry taken until the packet has ended
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
      tx_done  <= 1'b0;
      tx_fail  <= 1'b0;
      dly = -1;
    end else begin
      tx_done <= 1'b0;
      tx_fail <= 1'b0;
      if (tx_valid && tx_ready) begin
        for (int j = 0; j < 4; j++) begin
          if (tx_word.be[j]) got.push_back(tx_word.data[8*j+:8]);
        end
        if (tx_word.last) dly = 1 + ($random(seed) & 15);
      end
      if (dly == 0) begin
        tx_done <= 1'b1;
        tx_fail <= fail;
      end
      if (dly >= 0) dly--;
      tx_ready <= !stall && dly < 0 && ($random(seed) & 3) != 0;
    end
  end
endmodule // mac_model

// *** verif/tx_buffer_command_loader_tb.sv ***
// Purpose: Self-checking bench for the transmit buffer command loader.
// Assumes: APB master tasks here, MAC side from mac_model.
// Notes:   Expected bytes come from a queue model, status words from each packet's tag and error flags.
`timescale 1ns/1ps
module tx_buffer_command_loader_tb;
  localparam int DEPTH = 16;
  logic              pclk = 1'b0;
  logic              presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata;
  logic              tx_valid, tx_ready, tx_done, tx_fail, irq;
  logic              transmit_error_flag, buffer_loaded_flag, stall, fail, last_err;
  txl_pkg::tx_word_s tx_word;
  logic [7:0]        exp_q[$];
  int                seed = 28;
  int                miscompares = 0;
  int                num_checks = 0;
  // 40 MHz clock
  always #12.5 pclk = ~pclk;
  tx_buffer_command_loader #(.DATA_DEPTH(DEPTH)) dut (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_valid(tx_valid), .tx_word(tx_word), .tx_ready(tx_ready), .tx_done(tx_done),
    .tx_fail(tx_fail), .irq(irq), .transmit_error_flag(transmit_error_flag),
    .buffer_loaded_flag(buffer_loaded_flag));
  mac_model mac (.pclk(pclk), .presetn(presetn), .tx_valid(tx_valid), .tx_word(tx_word),
    .tx_ready(tx_ready), .tx_done(tx_done), .tx_fail(tx_fail), .stall(stall), .fail(fail));
  task automatic final_report();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  // One APB transfer, held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      miscompares++;
      final_report();
    end
    q = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    apb(1'b0, a, 32'h0, q);
  endtask
  // Command pair, then payload padded to the end alignment
  task automatic buf_send(input logic ioc, fst, lst, input int off, sz,
                          input logic [1:0] al, input logic [31:0] cb);
    int tot, u;
    logic [31:0] w;
    rd(txl_pkg::ADDR_SPACE, w);
    u = (al == 2'h1) ? 4 : (al == 2'h2) ? 8 : 1;
    tot = ((off + sz + 3) / 4 + u - 1) / u * u;
    wr(txl_pkg::ADDR_DATA, {ioc, 5'h0, al, 3'h0, 5'(off), 2'h0, fst, lst, 1'b0, 11'(sz)});
    wr(txl_pkg::ADDR_DATA, cb);
    for (int i = 0; i < tot; i++) begin
      w = $random(seed);
      for (int j = 0; j < 4; j++) begin
        if (i * 4 + j >= off && i * 4 + j < off + sz) exp_q.push_back(w[8*j+:8]);
      end
      wr(txl_pkg::ADDR_DATA, w);
    end
  endtask
  task automatic wait_st();
    logic [31:0] q;
    for (int n = 0; n < 100; n++) begin
      rd(txl_pkg::ADDR_SPACE, q);
      if (q[23:16] != 8'h00) return;
    end
    miscompares++;
    final_report();
  endtask
  task automatic chk_pkt(input logic [15:0] tg, input logic e, input logic f);
    logic [31:0] q;
    wait_st();
    rd(txl_pkg::ADDR_STATUS, q);
    chk("status", {tg, e | f, 13'h0, e, f}, q);
    if (!e) begin
      chk("count", 32'(exp_q.size()), 32'(mac.got.size()));
      foreach (exp_q[i]) chk("byte", {24'h0, exp_q[i]}, {24'h0, mac.got[i]});
    end
    exp_q.delete();
    mac.got.delete();
  endtask
  initial begin
    logic [31:0] q;
    logic [15:0] tg;
    int off, sz, s2, used;
    {ce, psel, penable, pwrite, paddr, pwdata, stall, fail} = '0;
    ce = 1'b1;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and an unmapped place
    rd(txl_pkg::ADDR_INT_MASK, q);
    chk("mask", 32'h0, q);
    rd(txl_pkg::ADDR_SPACE, q);
    chk("space", 32'(DEPTH * 4), q);
    rd(8'h1c, q);
    chk("slverr", 32'h1, {31'h0, last_err});
    wr(txl_pkg::ADDR_CONFIG, 32'h1);
    // Single-buffer packets over the 4-, 16- and 32-byte end alignments
    for (int k = 0; k < 3; k++) begin
      off = $random(seed) & 31;
      sz = 1 + ($random(seed) & 31);
      tg = 16'($random(seed));
      stall <= (k == 2);
      fail <= (k == 1);
      buf_send(1'b1, 1'b1, 1'b1, off, sz, 2'(k), {tg, 5'h0, 11'(sz)});
      rd(txl_pkg::ADDR_SPACE, q);
      used = (off + sz + 3) / 4 - off / 4 + 1;
      // One entry already waits in the output stage toward the stalled MAC
      if (k == 2) chk("space", 32'((DEPTH - used + 1) * 4), {16'h0, q[15:0]});
      chk("loaded", 32'h1, {31'h0, buffer_loaded_flag});
      stall <= 1'b0;
      wait_st();
      wr(txl_pkg::ADDR_INT_MASK, 32'h0);
      @(posedge pclk);
      chk("irq", 32'h0, {31'h0, irq});
      wr(txl_pkg::ADDR_INT_MASK, 32'h7);
      @(posedge pclk);
      chk("irq", 32'h1, {31'h0, irq});
      rd(txl_pkg::ADDR_INT_STS, q);
      chk("int", 32'h6, q & 32'h6);
      chk_pkt(tg, 1'b0, k == 1);
      rd(txl_pkg::ADDR_INT_STS, q);
      @(posedge pclk);
      chk("irq", 32'h0, {31'h0, irq});
    end
    // Two-buffer packets: clean, differing second command, wrong length, reserved alignment
    for (int m = 0; m < 4; m++) begin
      tg = 16'($random(seed));
      sz = 1 + ($random(seed) & 31);
      s2 = 1 + ($random(seed) & 31);
      q = {tg, 5'h0, 11'(sz + s2 + (m == 2))};
      buf_send(1'b0, 1'b1, 1'b0, $random(seed) & 31, sz, 2'(m == 3 ? 3 : 1), q);
      buf_send(1'b0, 1'b0, 1'b1, $random(seed) & 31, s2, 2'h0, q ^ 32'(m == 1));
      chk_pkt(tg, m != 0, 1'b0);
      rd(txl_pkg::ADDR_CTRL, q);
      chk("errflag", 32'(m != 0), {31'h0, q[0]});
      wr(txl_pkg::ADDR_CTRL, 32'h1);
      @(posedge pclk);
      chk("errclr", 32'h0, {31'h0, transmit_error_flag});
    end
    // Overfill with the MAC stalled, then reset in mid-run
    stall <= 1'b1;
    buf_send(1'b0, 1'b1, 1'b1, 0, DEPTH * 4 + 4, 2'h0, {16'h0, 5'h0, 11'(DEPTH * 4 + 4)});
    rd(txl_pkg::ADDR_CTRL, q);
    chk("overflow", 32'h1, {31'h0, transmit_error_flag});
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    stall <= 1'b0;
    rd(txl_pkg::ADDR_SPACE, q);
    chk("space", 32'(DEPTH * 4), q);
    chk("errrst", 32'h0, {31'h0, transmit_error_flag});
    final_report();
  end
endmodule // tx_buffer_command_loader_tb
